// ==== aleu_pkg.sv ====
// Package: operation codes, flag layout and request/answer carriers of the execution unit
`default_nettype none
package aleu_pkg;
    localparam int DATA_W = 8;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    // Flag bit positions in the status byte
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // Cycle counts
    localparam int BYTE_OP_CYCLES = 1;
    localparam int WORD_OP_CYCLES = 2;
    localparam logic [1:0] WORD_LAST_PHASE = 2'(WORD_OP_CYCLES - 1);

    typedef enum logic [4:0] {
        add_op,
        add_with_carry_op,
        word_add_immediate_op,
        subtract_op,
        subtract_immediate_op,
        subtract_with_borrow_op,
        subtract_immediate_with_borrow_op,
        word_subtract_immediate_op,
        and_op,
        and_immediate_op,
        or_op,
        or_immediate_op,
        exclusive_or_op,
        ones_complement_op,
        twos_complement_op,
        set_bits_by_mask_op,
        clear_bits_by_mask_op,
        increment_op,
        decrement_op
    } aleu_op_t;

    typedef struct packed {
        aleu_op_t op;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] dst_hi;
        logic [5:0] imm;
        logic [7:0] k;
    } aleu_req_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic hi_valid;
        logic [7:0] flags;
    } aleu_res_t;
endpackage
`default_nettype wire

// ==== aleu_add8.sv ====
// Byte adder with carry-in giving sum, carry out, half carry and overflow
`default_nettype none
module aleu_add8 #(
    parameter int W = 8
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic cin,
    output logic [W-1:0] sum,
    output logic cout,
    output logic half,
    output logic ovf
);
    logic [W:0] full;
    logic [4:0] low;

    // Subtraction is done by the caller as a plus inverted b plus one
    always_comb begin
        full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        sum = full[W-1:0];
        cout = full[W];
        half = low[4];
        ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
    end
endmodule
`default_nettype wire

// ==== aleu_core.sv ====
// Arithmetic and logic execution unit: byte and word operations with status flags
//
// Notes on behaviour
// - add and add-with-carry write sum, update Z C N V H, one cycle.
// - subtract and subtract-with-borrow write difference, update Z C N V H, one cycle.
// - subtract-immediate writes destination minus constant, Z C N V H, one cycle.
// - subtract-immediate-with-borrow also subtracts carry, Z C N V H, one cycle.
// - word add-immediate adds constant to pair, writes both halves, Z C N V S, two cycles.
// - word subtract-immediate subtracts constant from pair, Z C N V S, two cycles.
// - register and writes result, updates only Z N V, one cycle.
// - and with constant writes result, updates Z N V, one cycle.
// - register or writes result, updates Z N V, one cycle.
// - or with constant and set-bits-by-mask both write or, Z N V, one cycle.
// - clear-bits-by-mask ands with all-ones minus constant, Z N V, one cycle.
// - exclusive or writes result, updates Z N V, one cycle.
// - ones' complement is all-ones minus value, updates Z C N V, one cycle.
// - twos' complement is zero minus value, updates Z C N V H, one cycle.
// - increment adds one, updates only Z N V, carry kept, one cycle.
// - decrement subtracts one, updates only Z N V, carry kept, one cycle.
`default_nettype none
module aleu_core (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire aleu_pkg::aleu_req_t req,
    input wire logic [7:0] flags_in,
    output logic req_ready,
    output var aleu_pkg::aleu_res_t res,
    output logic res_valid,
    output logic [7:0] flags
);
    import aleu_pkg::*;

    typedef enum logic [0:0] {st_idle, st_word_hi} aleu_state_t;

    aleu_state_t state_r;
    aleu_state_t state_nxt;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    aleu_res_t res_r;
    aleu_res_t res_nxt;
    logic res_valid_r;
    logic res_valid_nxt;
    aleu_req_t word_r;
    logic word_carry_r;
    logic word_carry_nxt;
    logic [7:0] word_lo_r;
    logic [7:0] word_lo_nxt;

    logic [7:0] add_a;
    logic [7:0] add_b;
    logic add_cin;
    logic [7:0] add_sum;
    logic add_cout;
    logic add_half;
    logic add_ovf;

    logic is_sub;
    logic is_word;
    logic c_in;

    // The caller may also pass flags directly; the unit keeps its own copy
    assign c_in = flags_in[FLAG_C];
    assign is_word = req.op inside {word_add_immediate_op, word_subtract_immediate_op};

    ////////////////////////////////////////////////////////////////////////
    // Shared adder; subtract feeds inverted operand and inverted borrow
    always_comb begin
        add_a = req.dst;
        add_b = req.src;
        add_cin = 1'b0;
        is_sub = 1'b0;
        if (state_r == st_word_hi) begin
            // High byte of word op: zero-extended constant, chained carry
            add_a = word_r.dst_hi;
            is_sub = (word_r.op == word_subtract_immediate_op);
            add_b = is_sub ? ~ALL_ZERO : ALL_ZERO;
            add_cin = word_carry_r;
        end else begin
            case (req.op)
                add_op: begin
                    add_b = req.src;
                end
                add_with_carry_op: begin
                    add_b = req.src;
                    add_cin = c_in;
                end
                subtract_op: begin
                    is_sub = 1'b1;
                    add_b = ~req.src;
                    add_cin = 1'b1;
                end
                subtract_with_borrow_op: begin
                    is_sub = 1'b1;
                    add_b = ~req.src;
                    add_cin = ~c_in;
                end
                subtract_immediate_op: begin
                    is_sub = 1'b1;
                    add_b = ~req.k;
                    add_cin = 1'b1;
                end
                subtract_immediate_with_borrow_op: begin
                    is_sub = 1'b1;
                    add_b = ~req.k;
                    add_cin = ~c_in;
                end
                word_add_immediate_op: begin
                    add_b = {2'b00, req.imm};
                end
                word_subtract_immediate_op: begin
                    is_sub = 1'b1;
                    add_b = ~{2'b00, req.imm};
                    add_cin = 1'b1;
                end
                twos_complement_op: begin
                    is_sub = 1'b1;
                    add_a = ALL_ZERO;
                    add_b = ~req.dst;
                    add_cin = 1'b1;
                end
                increment_op: begin
                    add_b = ONE_BYTE;
                end
                decrement_op: begin
                    is_sub = 1'b1;
                    add_b = ~ONE_BYTE;
                    add_cin = 1'b1;
                end
                default: begin
                    add_b = req.src;
                end
            endcase
        end
    end

    aleu_add8 #(
        .W(DATA_W)
    ) i_aleu_add8 (
        .a(add_a),
        .b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .cout(add_cout),
        .half(add_half),
        .ovf(add_ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    // Result and flag selection
    always_comb begin
        logic [7:0] r;
        logic cflag;
        logic hflag;
        r = add_sum;
        // Borrow is the inverse of the adder carry when subtracting
        cflag = is_sub ? ~add_cout : add_cout;
        hflag = is_sub ? ~add_half : add_half;
        flags_nxt = flags_r;
        res_nxt = res_r;
        res_valid_nxt = 1'b0;
        state_nxt = state_r;
        word_carry_nxt = word_carry_r;
        word_lo_nxt = word_lo_r;
        if (state_r == st_word_hi) begin
            // Second cycle finishes the pair; zero covers both halves
            res_nxt.lo = word_lo_r;
            res_nxt.hi = r;
            res_nxt.hi_valid = 1'b1;
            res_valid_nxt = 1'b1;
            flags_nxt[FLAG_C] = cflag;
            flags_nxt[FLAG_Z] = (r == ALL_ZERO) && (word_lo_r == ALL_ZERO);
            flags_nxt[FLAG_N] = r[7];
            flags_nxt[FLAG_V] = add_ovf;
            flags_nxt[FLAG_S] = r[7] ^ add_ovf;
            state_nxt = st_idle;
        end else if (req_valid && is_word) begin
            // Low byte now, its carry held for the high byte
            word_lo_nxt = r;
            word_carry_nxt = add_cout;
            state_nxt = st_word_hi;
        end else if (req_valid) begin
            res_valid_nxt = 1'b1;
            res_nxt.hi = ALL_ZERO;
            res_nxt.hi_valid = 1'b0;
            case (req.op)
                and_op: r = req.dst & req.src;
                and_immediate_op: r = req.dst & req.k;
                or_op: r = req.dst | req.src;
                or_immediate_op, set_bits_by_mask_op: r = req.dst | req.k;
                clear_bits_by_mask_op: r = req.dst & (ALL_ONES - req.k);
                exclusive_or_op: r = req.dst ^ req.src;
                ones_complement_op: r = ALL_ONES - req.dst;
                default: r = add_sum;
            endcase
            res_nxt.lo = r;
            flags_nxt[FLAG_Z] = (r == ALL_ZERO);
            flags_nxt[FLAG_N] = r[7];
            case (req.op)
                // Arithmetic: carry, overflow and half carry all come from the shared adder
                add_op, add_with_carry_op: begin
                    flags_nxt[FLAG_C] = cflag;
                    flags_nxt[FLAG_V] = add_ovf;
                    flags_nxt[FLAG_H] = hflag;
                end
                subtract_op, subtract_with_borrow_op: begin
                    flags_nxt[FLAG_C] = cflag;
                    flags_nxt[FLAG_V] = add_ovf;
                    flags_nxt[FLAG_H] = hflag;
                end
                subtract_immediate_op: begin
                    flags_nxt[FLAG_C] = cflag;
                    flags_nxt[FLAG_V] = add_ovf;
                    flags_nxt[FLAG_H] = hflag;
                end
                subtract_immediate_with_borrow_op: begin
                    flags_nxt[FLAG_C] = cflag;
                    flags_nxt[FLAG_V] = add_ovf;
                    flags_nxt[FLAG_H] = hflag;
                end
                twos_complement_op: begin
                    flags_nxt[FLAG_C] = cflag;
                    flags_nxt[FLAG_V] = add_ovf;
                    flags_nxt[FLAG_H] = hflag;
                end
                ones_complement_op: begin
                    flags_nxt[FLAG_C] = 1'b1;
                    flags_nxt[FLAG_V] = 1'b0;
                end
                increment_op: begin
                    flags_nxt[FLAG_V] = add_ovf;
                end
                decrement_op: begin
                    flags_nxt[FLAG_V] = add_ovf;
                end
                and_op: begin
                    flags_nxt[FLAG_V] = 1'b0;
                end
                and_immediate_op: begin
                    flags_nxt[FLAG_V] = 1'b0;
                end
                or_op: begin
                    flags_nxt[FLAG_V] = 1'b0;
                end
                or_immediate_op, set_bits_by_mask_op: begin
                    flags_nxt[FLAG_V] = 1'b0;
                end
                clear_bits_by_mask_op: begin
                    flags_nxt[FLAG_V] = 1'b0;
                end
                exclusive_or_op: begin
                    flags_nxt[FLAG_V] = 1'b0;
                end
                // Unknown codes act as an add but touch flags like a logic op
                default: begin
                    flags_nxt[FLAG_V] = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State machine; word ops hold off new requests for their second cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= st_idle;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Word request capture for the high-byte cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            word_r <= '0;
            word_carry_r <= 1'b0;
            word_lo_r <= ALL_ZERO;
        end else begin
            if (state_r == st_idle && req_valid && is_word) begin
                word_r <= req;
            end
            word_carry_r <= word_carry_nxt;
            word_lo_r <= word_lo_nxt;
        end
    end

    // Status flags
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Result register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            res_r <= '0;
            res_valid_r <= 1'b0;
        end else begin
            res_r <= res_nxt;
            res_valid_r <= res_valid_nxt;
        end
    end

    assign req_ready = (state_r == st_idle);
    assign res = res_r;
    assign res_valid = res_valid_r;
    assign flags = flags_r;
endmodule
`default_nettype wire

// ==== aleu_core_monitor.sv ====
// Checker: port timing, results and flag relations of the execution unit
`default_nettype none
module aleu_core_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire aleu_pkg::aleu_req_t req,
    input wire logic [7:0] flags_in,
    input wire logic req_ready,
    input wire aleu_pkg::aleu_res_t res,
    input wire logic res_valid,
    input wire logic [7:0] flags
);
    timeunit 1ns;
    timeprecision 1ps;
    import aleu_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic tk;
    logic wop;
    // Taking edge, and whether the taken request is a word operation
    assign tk = req_valid && req_ready;
    assign wop = req.op inside {word_add_immediate_op, word_subtract_immediate_op};
    ////////////////////////////////////////////////////////////////////////////////
    property p_byte; tk && !wop |=> res_valid && !res.hi_valid; endproperty
    a_byte: assert property (p_byte) else $error("byte answer late");
    // Word op stalls the feeder one cycle, answers on the second edge
    property p_word; tk && wop |=> !req_ready && !res_valid ##1 res_valid && res.hi_valid && req_ready; endproperty
    a_word: assert property (p_word) else $error("word timing wrong");
    property p_add; tk && req.op == add_op |=> res.lo == 8'($past(req.dst) + $past(req.src)); endproperty
    a_add: assert property (p_add) else $error("sum wrong");
    property p_sub; tk && req.op == subtract_op |=> res.lo == 8'($past(req.dst) - $past(req.src)); endproperty
    a_sub: assert property (p_sub) else $error("difference wrong");
    property p_xor; tk && req.op == exclusive_or_op |=> res.lo == ($past(req.dst) ^ $past(req.src)); endproperty
    a_xor: assert property (p_xor) else $error("xor wrong");
    property p_com; tk && req.op == ones_complement_op |=> res.lo == 8'(ALL_ONES - $past(req.dst)); endproperty
    a_com: assert property (p_com) else $error("complement wrong");
    property p_neg; tk && req.op == twos_complement_op |=> res.lo == 8'(ALL_ZERO - $past(req.dst)); endproperty
    a_neg: assert property (p_neg) else $error("negation wrong");
    property p_inc; tk && req.op inside {increment_op, decrement_op} |=> $stable(flags[FLAG_C]); endproperty
    a_inc: assert property (p_inc) else $error("carry moved on step");
    // Register and, or and exclusive or must not touch carry, half carry or sign
    property p_keep;
        tk && req.op inside {and_op, or_op, exclusive_or_op}
            |=> $stable(flags[FLAG_C]) && $stable(flags[FLAG_H]) && $stable(flags[FLAG_S]);
    endproperty
    a_keep: assert property (p_keep) else $error("unnamed flag moved");
    property p_zn; res_valid && !res.hi_valid |-> flags[FLAG_Z] == (res.lo == ALL_ZERO) && flags[FLAG_N] == res.lo[7];
    endproperty
    a_zn: assert property (p_zn) else $error("zero or negative wrong");
    property p_sgn;
        res_valid && res.hi_valid |-> flags[FLAG_S] == (flags[FLAG_N] ^ flags[FLAG_V])
            && flags[FLAG_Z] == ({res.hi, res.lo} == 16'h0000);
    endproperty
    a_sgn: assert property (p_sgn) else $error("word sign or zero wrong");
    c_word: cover property (tk && wop);
    c_carry: cover property (tk && req.op == add_with_carry_op && flags_in[FLAG_C]);
    c_neg: cover property (tk && req.op == twos_complement_op);
endmodule
bind aleu_core aleu_core_monitor i_aleu_core_monitor (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .flags_in(flags_in), .req_ready(req_ready), .res(res), .res_valid(res_valid), .flags(flags));
`default_nettype wire

// ==== aleu_feed.sv ====
// Behavioural decoder and register file: issues requests, loops status back
`default_nettype none
module aleu_feed (
    input wire logic ref_clk,
    input wire logic req_ready,
    input wire logic [7:0] flags,
    output logic req_valid,
    output var aleu_pkg::aleu_req_t req,
    output logic [7:0] flags_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import aleu_pkg::*;
    // Carry for chained arithmetic comes from the live status byte
    assign flags_in = flags;
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // Holds the request until an edge with ready high, for at most 9 edges; idle bus shows garbage
    task automatic send(input aleu_op_t op, input logic [7:0] d, input logic [7:0] s, input logic [7:0] h,
                        input logic [5:0] i, input logic [7:0] k);
        int n;
        @(posedge ref_clk);
        #1;
        req_valid = 1'b1;
        req = '{op: op, dst: d, src: s, dst_hi: h, imm: i, k: k};
        n = 0;
        while (!req_ready && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        #1;
        req_valid = 1'b0;
        req = aleu_req_t'(~req);
    endtask
endmodule
`default_nettype wire

// ==== aleu_core_test.sv ====
// Self-checking bench for the execution unit
`default_nettype none
module aleu_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aleu_pkg::*;
    logic ref_clk;
    logic rst;
    logic req_valid;
    logic req_ready;
    logic res_valid;
    logic [7:0] flags_in;
    logic [7:0] flags;
    aleu_req_t req;
    aleu_res_t res;
    int fails;
    int n_tests;
    aleu_core i_aleu_core (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req), .flags_in(flags_in),
        .req_ready(req_ready), .res(res), .res_valid(res_valid), .flags(flags));
    aleu_feed i_aleu_feed (.ref_clk(ref_clk), .req_ready(req_ready), .flags(flags), .req_valid(req_valid),
        .req(req), .flags_in(flags_in));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Byte op: answer on the taking edge itself
    task automatic bop(input aleu_op_t op, input logic [7:0] d, input logic [7:0] s, input logic [7:0] k,
                       input logic [7:0] lo, input logic [7:0] fl);
        i_aleu_feed.send(op, d, s, 8'h00, 6'h00, k);
        chk("valid", {7'h00, res_valid}, 8'h01);
        chk("result", res.lo, lo);
        chk("flags", flags, fl);
    endtask
    // Word op: ready drops for one cycle, answer on the second edge
    task automatic wop(input aleu_op_t op, input logic [7:0] h, input logic [7:0] l, input logic [5:0] i,
                       input logic [7:0] ehi, input logic [7:0] elo, input logic [7:0] fl);
        i_aleu_feed.send(op, l, 8'h00, h, i, 8'h00);
        chk("stall", {6'h00, req_ready, res_valid}, 8'h00);
        @(posedge ref_clk);
        #1;
        chk("valid", {6'h00, res_valid, res.hi_valid}, 8'h03);
        chk("high", res.hi, ehi);
        chk("low", res.lo, elo);
        chk("flags", flags, fl);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_add;
        bop(add_op, 8'h0f, 8'h01, 8'h00, 8'h10, 8'h20);
        bop(add_with_carry_op, 8'hff, 8'h01, 8'h00, 8'h00, 8'h23);
        bop(add_with_carry_op, 8'h7f, 8'h00, 8'h00, 8'h80, 8'h2c);
        $display("add done");
    endtask
    task automatic t_sub;
        bop(subtract_op, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h20);
        bop(subtract_immediate_op, 8'h05, 8'h00, 8'h05, 8'h00, 8'h02);
        bop(subtract_immediate_op, 8'h00, 8'h00, 8'h01, 8'hff, 8'h25);
        bop(subtract_immediate_with_borrow_op, 8'h03, 8'h00, 8'h01, 8'h01, 8'h00);
        bop(subtract_immediate_op, 8'h00, 8'h00, 8'h01, 8'hff, 8'h25);
        bop(subtract_with_borrow_op, 8'h80, 8'h00, 8'h00, 8'h7f, 8'h28);
        $display("subtract done");
    endtask
    task automatic t_word;
        wop(word_subtract_immediate_op, 8'h00, 8'h3f, 6'h3f, 8'h00, 8'h00, 8'h22);
        wop(word_add_immediate_op, 8'h7f, 8'hff, 6'h01, 8'h80, 8'h00, 8'h2c);
        wop(word_subtract_immediate_op, 8'h00, 8'h00, 6'h01, 8'hff, 8'hff, 8'h35);
        $display("word done");
    endtask
    // Carry, sign and half carry are all set on entry and must survive
    task automatic t_logic;
        bop(and_op, 8'hf0, 8'h0f, 8'h00, 8'h00, 8'h33);
        bop(or_op, 8'h80, 8'h01, 8'h00, 8'h81, 8'h35);
        bop(and_immediate_op, 8'hc3, 8'h00, 8'h81, 8'h81, 8'h35);
        bop(or_immediate_op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h33);
        bop(exclusive_or_op, 8'haa, 8'haa, 8'h00, 8'h00, 8'h33);
        bop(set_bits_by_mask_op, 8'h01, 8'h00, 8'h80, 8'h81, 8'h35);
        bop(clear_bits_by_mask_op, 8'hff, 8'h00, 8'h0f, 8'hf0, 8'h35);
        $display("logic done");
    endtask
    task automatic t_unary;
        bop(ones_complement_op, 8'hf0, 8'h00, 8'h00, 8'h0f, 8'h31);
        bop(twos_complement_op, 8'h80, 8'h00, 8'h00, 8'h80, 8'h1d);
        bop(decrement_op, 8'h80, 8'h00, 8'h00, 8'h7f, 8'h19);
        bop(increment_op, 8'hff, 8'h00, 8'h00, 8'h00, 8'h13);
        bop(twos_complement_op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h12);
        bop(twos_complement_op, 8'h01, 8'h00, 8'h00, 8'hff, 8'h35);
        $display("unary done");
    endtask
    // Whole run is about 65 cycles; cut off well beyond that
    initial begin
        #20000;
        fails++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        t_add();
        t_sub();
        t_word();
        t_logic();
        t_unary();
        test_done();
    end
endmodule
`default_nettype wire
